// file: src/atl_map.vh
// timing counts and word layout for the attenuator word loader
`ifndef ATL_MAP_VH
`define ATL_MAP_VH
`define ATL_CLK_NS 25
`define ATL_WORD_BITS 6
`define ATL_START_BIT 5
`define ATL_SCK_HIGH_NS 50
`define ATL_SCK_LOW_NS 50
`define ATL_SCK_HIGH_CYC ((`ATL_SCK_HIGH_NS + `ATL_CLK_NS - 1) / `ATL_CLK_NS)
`define ATL_SCK_LOW_CYC ((`ATL_SCK_LOW_NS + `ATL_CLK_NS - 1) / `ATL_CLK_NS)
`define ATL_LE_SETUP_NS 10
`define ATL_LE_SETUP_CYC ((`ATL_LE_SETUP_NS + `ATL_CLK_NS - 1) / `ATL_CLK_NS)
`define ATL_LE_PW_SER_NS 30
`define ATL_LE_PW_SER_CYC ((`ATL_LE_PW_SER_NS + `ATL_CLK_NS - 1) / `ATL_CLK_NS)
`define ATL_LE_PW_PAR_NS 10
`define ATL_LE_PW_PAR_CYC ((`ATL_LE_PW_PAR_NS + `ATL_CLK_NS - 1) / `ATL_CLK_NS)
`define ATL_PD_SETUP_NS 10
`define ATL_PD_SETUP_CYC ((`ATL_PD_SETUP_NS + `ATL_CLK_NS - 1) / `ATL_CLK_NS)
`define ATL_PD_HOLD_NS 10
`define ATL_PD_HOLD_CYC ((`ATL_PD_HOLD_NS + `ATL_CLK_NS - 1) / `ATL_CLK_NS)
`endif

// file: src/atl_loader.v
// controller that loads attenuation words into the step attenuator
`timescale 1ns/10ps
`include "atl_map.vh"
module atl_loader (
    input wire mclk,
    input wire rst,
    input wire start,
    input wire serial_mode,
    input wire [4:0] atten_word,
    input wire preset_high,
    output reg busy,
    output reg done,
    output reg interface_select,
    output reg powerup_preset_select,
    output reg serial_clock,
    output reg serial_data,
    output reg latch_strobe,
    output reg atten_sel_8db,
    output reg atten_sel_4db,
    output reg atten_sel_2db,
    output reg atten_sel_1db,
    output reg atten_sel_half_db
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_LOW = 6'h02;
    localparam [5:0] ST_HIGH = 6'h04;
    localparam [5:0] ST_LESU = 6'h08;
    localparam [5:0] ST_LEHI = 6'h10;
    localparam [5:0] ST_HOLD = 6'h20;

    reg [5:0] state;
    reg [5:0] next_state;
    reg [5:0] shift;
    reg [2:0] bits_left;
    reg [3:0] cnt;
    reg [3:0] next_cnt;
    reg ser;
    reg data_due;
    wire timer_out;

    // count of cycles for a wait, minus one, at counter width
    function [3:0] wait_of;
        input integer cycles;
        begin
            wait_of = cycles[3:0] - 4'h1;
        end
    endfunction

    // frame on the wire: start bit low, then the five selects
    function [5:0] frame_of;
        input [4:0] sel;
        begin
            frame_of = {1'b0, sel};
        end
    endfunction

    assign timer_out = (cnt == 4'h0);

    // sequencing: state and wait counter
    always @* begin
        next_state = state;
        if (timer_out) begin
            next_cnt = 4'h0;
        end else begin
            next_cnt = cnt - 4'h1;
        end
        case (state)
            ST_IDLE: begin
                next_cnt = 4'h0;
                if (start) begin
                    if (serial_mode) begin
                        next_cnt = wait_of(`ATL_SCK_LOW_CYC);
                        next_state = ST_LOW;
                    end else begin
                        next_cnt = wait_of(`ATL_PD_SETUP_CYC);
                        next_state = ST_LESU;
                    end
                end
            end
            ST_LOW: begin
                if (timer_out) begin
                    next_cnt = wait_of(`ATL_SCK_HIGH_CYC);
                    next_state = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (timer_out) begin
                    if (bits_left == 3'h0) begin
                        next_cnt = wait_of(`ATL_LE_SETUP_CYC);
                        next_state = ST_LESU;
                    end else begin
                        next_cnt = wait_of(`ATL_SCK_LOW_CYC);
                        next_state = ST_LOW;
                    end
                end
            end
            ST_LESU: begin
                if (timer_out) begin
                    if (ser) begin
                        next_cnt = wait_of(`ATL_LE_PW_SER_CYC);
                    end else begin
                        next_cnt = wait_of(`ATL_LE_PW_PAR_CYC);
                    end
                    next_state = ST_LEHI;
                end
            end
            ST_LEHI: begin
                if (timer_out) begin
                    next_cnt = wait_of(`ATL_PD_HOLD_CYC);
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (timer_out) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_cnt = 4'h0;
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // pins follow the state; every output comes from a flip-flop
    always @(posedge mclk) begin
        if (rst) begin
            shift <= 6'h00;
            bits_left <= 3'h0;
            ser <= 1'b0;
            data_due <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            interface_select <= 1'b0;
            powerup_preset_select <= 1'b0;
            serial_clock <= 1'b0;
            serial_data <= 1'b0;
            latch_strobe <= 1'b0;
            {atten_sel_8db, atten_sel_4db, atten_sel_2db, atten_sel_1db,
                atten_sel_half_db} <= 5'h00;
        end else begin
            done <= 1'b0;
            powerup_preset_select <= preset_high;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        busy <= 1'b1;
                        ser <= serial_mode;
                        interface_select <= serial_mode;
                        latch_strobe <= 1'b0;
                        if (serial_mode) begin
                            shift <= frame_of(atten_word);
                            serial_data <= 1'b0;
                            bits_left <= 3'h5;
                            data_due <= 1'b0;
                        end else begin
                            {atten_sel_8db, atten_sel_4db, atten_sel_2db,
                                atten_sel_1db, atten_sel_half_db}
                                <= atten_word;
                        end
                    end
                end
                ST_LOW: begin
                    // next bit one cycle after the fall: hold and setup
                    // both get a full cycle; needs a low phase of two
                    if (data_due) begin
                        shift <= {shift[4:0], 1'b0};
                        serial_data <= shift[4];
                        data_due <= 1'b0;
                    end
                    if (timer_out) begin
                        serial_clock <= 1'b1;
                    end
                end
                ST_HIGH: begin
                    if (timer_out) begin
                        serial_clock <= 1'b0;
                        if (bits_left != 3'h0) begin
                            bits_left <= bits_left - 3'h1;
                            data_due <= 1'b1;
                        end
                    end
                end
                ST_LESU: begin
                    if (timer_out) begin
                        latch_strobe <= 1'b1;
                    end
                end
                ST_LEHI: begin
                    if (timer_out) begin
                        latch_strobe <= 1'b0;
                    end
                end
                ST_HOLD: begin
                    // lines and data held past the strobe fall
                    if (timer_out) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
                default: begin
                    busy <= 1'b0;
                end
            endcase
        end
    end
endmodule // atl_loader

// file: verification/atl_dev_model.sv
// behavioural attenuator: shift register, latch, parallel path
`timescale 1ns/10ps
module atl_dev_model (input wire rst, ps, pup, sck, sdi, le,
    input wire [4:0] par, output reg [5:0] sr, output reg [4:0] att);
    initial sr = 6'h00;
    always @(posedge sck) sr <= {sr[4:0], sdi};
    // a set start bit leaves the state undefined
    always @* if (le) att = ps ? (sr[5] ? 5'bx : sr[4:0]) : par;
    always @(negedge rst) if (!le) att = ps ? par : {pup, 4'h0};
endmodule // atl_dev_model

// file: verification/atl_loader_chk.sv
// timing checks on the loader pins
`timescale 1ns/10ps
module atl_loader_chk (input wire mclk, rst, start, busy, done,
    interface_select, serial_clock, serial_data, latch_strobe,
    atten_sel_8db, atten_sel_4db, atten_sel_2db, atten_sel_1db,
    atten_sel_half_db);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire [4:0] par = {atten_sel_8db, atten_sel_4db, atten_sel_2db,
        atten_sel_1db, atten_sel_half_db};
    sequence s_le_rise; $rose(latch_strobe); endsequence
    sequence s_le_hold; latch_strobe [*2]; endsequence
    a_le_width: assert property (
        interface_select && $rose(latch_strobe) |-> s_le_hold) else $error("le");
    a_le_after_fall: assert property (
        s_le_rise |-> !serial_clock && !$past(serial_clock)) else $error("les");
    a_sck_high: assert property (
        $rose(serial_clock) |=> serial_clock) else $error("sck high");
    a_sck_low: assert property (
        $fell(serial_clock) |=> !serial_clock) else $error("sck low");
    a_data_hold: assert property (
        serial_clock |-> $stable(serial_data)) else $error("sdi");
    a_data_hold_fall: assert property (
        $fell(serial_clock) |-> $stable(serial_data)) else $error("sdi hold");
    a_shift_le_low: assert property (
        serial_clock |-> !latch_strobe) else $error("shift le");
    a_start_zero: assert property (
        $rose(busy) && interface_select |-> !serial_data) else $error("b5");
    a_par_stable: assert property (
        latch_strobe || $past(latch_strobe) |-> $stable(par)) else $error("par");
    a_par_len: assert property (
        $rose(busy) && !interface_select |-> ##3 done) else $error("plen");
    a_done_idle: assert property (
        done |-> !busy && !latch_strobe ##1 !done) else $error("done");
    a_take_busy: assert property (
        start && !busy |=> busy) else $error("take");
endmodule // atl_loader_chk
bind atl_loader atl_loader_chk u_chk (.*);

// file: verification/tb_atl_loader.sv
// loads random words both ways and compares the device state
`timescale 1ns/10ps
module tb_atl_loader;
    reg mclk = 0, rst = 1, start = 0, serial_mode = 0, preset_high = 0;
    reg [4:0] atten_word = 5'h00, w;
    wire busy, done, ps, pup, sck, sdi, le;
    wire [4:0] par, att;
    wire [5:0] sr;
    integer err_total = 0, n_compared = 0, seed = 60, cyc = 0, i, k;
    integer exp_q[$];
    always #12.5 mclk = ~mclk;
    atl_loader u_dut (.mclk(mclk), .rst(rst), .start(start), .busy(busy),
        .serial_mode(serial_mode), .atten_word(atten_word), .done(done),
        .preset_high(preset_high), .interface_select(ps),
        .powerup_preset_select(pup), .serial_clock(sck), .serial_data(sdi),
        .latch_strobe(le), .atten_sel_8db(par[4]), .atten_sel_4db(par[3]),
        .atten_sel_2db(par[2]), .atten_sel_1db(par[1]),
        .atten_sel_half_db(par[0]));
    atl_dev_model u_dev (.rst(rst), .ps(ps), .pup(pup), .sck(sck),
        .sdi(sdi), .le(le), .par(par), .sr(sr), .att(att));
    task end_of_test;
        begin
            $display("errors %0d compared %0d", err_total, n_compared);
            if (err_total == 0 && n_compared > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [4:0] got, input [4:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 0;
        @(negedge mclk);
        chk(att, 5'h00);
        for (i = 0; i < 24; i = i + 1) begin
            w = i < 2 ? {5{i[0]}} : $random(seed);
            @(posedge mclk);
            start <= 1;
            serial_mode <= i[0] ^ i[2];
            atten_word <= w;
            preset_high <= $random(seed);
            exp_q.push_back(w);
            @(posedge mclk);
            // second request while busy must be dropped
            atten_word <= ~w;
            @(posedge mclk);
            start <= 0;
            k = 0;
            while (done !== 1'b1 && k < 100) begin
                @(negedge mclk);
                k = k + 1;
            end
            if (k == 100) begin
                err_total = err_total + 1;
                $display("BAD %0t no done", $time);
            end
            chk(att, exp_q.pop_front());
            chk({4'h0, pup}, {4'h0, preset_high});
            if (serial_mode) chk({4'h0, sr[5]}, 5'h00);
        end
        end_of_test;
    end
endmodule // tb_atl_loader
